/* tb/pgd_assertions.sv */
`timescale 1ns/1ps
module pgd_chk (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic IO_WR_I,
	input wire logic MEM_WR_I,
	input wire logic MEM_RD_I,
	input wire logic MEM_RVALID_O,
	input wire logic PLANE_RVALID_I,
	input wire logic PLANE_RD_O,
	input wire logic PLANE_WR_O,
	input wire logic GFX_MODE_O,
	input wire logic [1:0] MEM_MAP_O,
	input wire logic SHIFT_FMT_O,
	input wire logic LOAD_256_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);
	// read walk: plane request, plane answer, cpu answer
	sequence s_plane_ans;
		PLANE_RVALID_I;
	endsequence
	sequence s_rd_walk;
		PLANE_RD_O ##[1:8] s_plane_ans;
	endsequence
	a_rd_done: assert property (s_rd_walk |=> MEM_RVALID_O)
		else $error("cpu read answer missing");
	a_rd_src: assert property (MEM_RVALID_O |-> $past(PLANE_RVALID_I))
		else $error("cpu read answer without plane data");
	a_wr_req: assert property (PLANE_WR_O |-> $past(MEM_WR_I))
		else $error("plane write without cpu write");
	// a write in the same cycle wins, so no plane read may follow it
	a_rd_req: assert property (PLANE_RD_O |-> $past(MEM_RD_I) && !$past(MEM_WR_I))
		else $error("plane read without lone cpu read");
	// mode levels move only after a register write, one or two cycles on
	a_gfx_src: assert property (!$stable(GFX_MODE_O) |-> $past(IO_WR_I) || $past(IO_WR_I, 2))
		else $error("graphics mode moved without write");
	a_map_src: assert property (!$stable(MEM_MAP_O) |-> $past(IO_WR_I) || $past(IO_WR_I, 2))
		else $error("memory map moved without write");
	a_load_src: assert property (!$stable(LOAD_256_O) |-> $past(IO_WR_I) || $past(IO_WR_I, 2))
		else $error("256 colour load moved without write");
	a_fmt_excl: assert property (SHIFT_FMT_O |-> !LOAD_256_O)
		else $error("shift format active with 256 colour load");
endmodule

bind pgd_datapath pgd_chk u_chk (.SYS_CLK_I, .RST_I, .IO_WR_I, .MEM_WR_I,
	.MEM_RD_I, .MEM_RVALID_O, .PLANE_RVALID_I, .PLANE_RD_O, .PLANE_WR_O,
	.GFX_MODE_O, .MEM_MAP_O, .SHIFT_FMT_O, .LOAD_256_O);

/* tb/pgd_plane_mem.sv */
`timescale 1ns/1ps
module pgd_plane_mem (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [15:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] sel_i,
	output logic [31:0] rdata_o,
	output logic rvalid_o
);
	logic [31:0] mem [16];
	logic [3:0] a;
	int w;
	logic slow;
	// four planes; latency alternates between 2 and 5 cycles
	always @(posedge clk_i) begin
		rvalid_o <= 1'b0;
		rdata_o <= ~rdata_o; // idle bus flips every bit of the last word each cycle
		if (rst_i) begin
			w <= 0;
			slow <= 1'b0;
			rdata_o <= 32'h0;
			for (int i = 0; i < 16; i++) mem[i] <= 32'h0;
		end else begin
			for (int p = 0; p < 4; p++)
				if (wr_i && sel_i[p]) mem[addr_i[3:0]][8*p+:8] <= wdata_i[8*p+:8];
			if (w == 1) begin
				rdata_o <= mem[a];
				rvalid_o <= 1'b1;
			end
			if (rd_i) begin
				a <= addr_i[3:0];
				w <= slow ? 4 : 1;
				slow <= ~slow;
			end else if (w != 0) w <= w - 1;
		end
	end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import pgd_pkg::*;
;
	logic clk = 0, rst = 1, iow = 0, mw = 0, mr = 0, rm;
	logic [15:0] ioa = 0, ma = 0, pa;
	logic [7:0] iod = 0, md = 0, rdo, mk, x;
	logic rv, prd, pwr, pv, gfx, sfm, l256;
	logic [31:0] pwd, prdata, lat, sh [16];
	logic [3:0] psel, fv, fe, cc, ce, a;
	logic [1:0] map, wm, fn, rp;
	logic [2:0] rot;
	logic [7:0] q [$];
	logic [7:0] qi [$];
	logic iord = 0, iov, ch = 0, oe = 0;
	logic [7:0] iodo;
	int n_mismatch = 0, tests_run = 0, seed = 32'h57de3ba3;
	always #2 clk = ~clk;
	pgd_datapath dut (.SYS_CLK_I(clk), .RST_I(rst), .IO_WR_I(iow),
		.IO_RD_I(iord), .IO_ADDR_I(ioa), .IO_WDATA_I(iod),
		.IO_RDATA_O(iodo), .IO_RVALID_O(iov), .MEM_WR_I(mw),
		.MEM_RD_I(mr), .MEM_ADDR_I(ma),
		.MEM_WDATA_I(md), .MEM_RDATA_O(rdo), .MEM_RVALID_O(rv),
		.PLANE_RDATA_I(prdata), .PLANE_RVALID_I(pv), .PLANE_RD_O(prd),
		.PLANE_WR_O(pwr), .PLANE_ADDR_O(pa), .PLANE_WDATA_O(pwd),
		.PLANE_SEL_O(psel), .GFX_MODE_O(gfx), .MEM_MAP_O(map),
		.SHIFT_FMT_O(sfm), .LOAD_256_O(l256));
	pgd_plane_mem u_mem (.clk_i(clk), .rst_i(rst), .rd_i(prd), .wr_i(pwr),
		.addr_i(pa), .wdata_i(pwd), .sel_i(psel), .rdata_o(prdata),
		.rvalid_o(pv));
	task cmp(string n, logic [7:0] e, logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task test_done;
		if (q.size() != 0 || qi.size() != 0) n_mismatch++;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// index then data write, each a one-cycle strobe
	task rg(logic [3:0] i, logic [7:0] d);
		@(negedge clk) {iow, ioa, iod} = {1'b1, PGD_PORT_INDEX, 4'h0, i};
		@(negedge clk) {iow, ioa, iod} = {1'b1, PGD_PORT_DATA, d};
		@(negedge clk) iow = 0;
	endtask
	// index write, then a one-cycle data-port read noting the expected byte
	task rq(logic [3:0] i, logic [7:0] e);
		@(negedge clk) {iow, ioa, iod} = {1'b1, PGD_PORT_INDEX, 4'h0, i};
		@(negedge clk) {iow, iord, ioa} = {1'b0, 1'b1, PGD_PORT_DATA};
		qi.push_back(e);
		@(negedge clk) iord = 0;
		@(negedge clk);
	endtask
	// expected plane bytes for one cpu write
	function logic [31:0] ew(logic [7:0] d);
		logic [7:0] r, s, m, l;
		r = (d >> rot) | (d << (4'd8 - rot));
		m = wm == PGD_WM3 ? r & mk : mk;
		for (int p = 0; p < 4; p++) begin
			l = lat[8*p+:8];
			s = wm == PGD_WM2 ? {8{d[p]}} : r;
			if (wm == PGD_WM3 || fe[p]) s = {8{fv[p]}};
			case (fn)
				2'h1: s = s & l;
				2'h2: s = s | l;
				2'h3: s = s ^ l;
				default: ;
			endcase
			ew[8*p+:8] = wm == PGD_WM1 ? l : (s & m) | (l & ~m);
		end
	endfunction
	// expected cpu read byte: plane select or colour compare
	function logic [7:0] er(logic [31:0] v, logic a0);
		logic [7:0] r;
		for (int j = 0; j < 8; j++)
			r[j] = &(~({v[24+j], v[16+j], v[8+j], v[j]} ^ cc) | ~ce);
		return rm ? r : v[8*(oe ? {rp[1], a0} : rp)+:8];
	endfunction
	// one cpu access; a read waits for its answer under a bound
	task mem(bit w, logic [3:0] ad);
		logic [3:0] b;
		logic [31:0] e;
		// chaining folds a0 into plane choice; the row drops a0
		b = ch ? {ad[3:1], 1'b0} : ad;
		@(negedge clk);
		{ma, md, mw, mr} = {12'h0, ad, 8'($random(seed)), w, !w};
		if (w) begin
			e = ew(md);
			for (int p = 0; p < 4; p++)
				if (!ch || ad[0] == p[0]) sh[b][8*p+:8] = e[8*p+:8];
		end else begin
			q.push_back(er(sh[b], ad[0]));
			lat = sh[b];
		end
		@(negedge clk) {mw, mr} = 2'b00;
		for (int k = 0; k < 20 && !w && rv !== 1'b1; k++) @(negedge clk);
		@(negedge clk);
	endtask
	// the answer stands one cycle, so it is taken at the next edge
	always @(posedge clk)
		if (rv === 1'b1) cmp("rdata", q.size() ? q.pop_front() : 8'hxx, rdo);
	// register readback answers stand one cycle as well
	always @(posedge clk)
		if (iov === 1'b1) cmp("ioreg", qi.size() ? qi.pop_front() : 8'hxx, iodo);
	initial begin
		#100000;
		n_mismatch++;
		test_done;
	end
	// odd/even and chaining stay off so every plane is written
	initial begin
		for (int i = 0; i < 16; i++) sh[i] = 32'h0;
		repeat (4) @(negedge clk);
		rst = 0;
		for (int i = 0; i < 48; i++) begin
			a = 4'($random(seed));
			wm = 2'(i);
			{fn, rot, mk} = 13'($random(seed));
			{fv, fe, cc, ce} = 16'($random(seed));
			x = 8'($random(seed));
			{rm, rp} = x[2:0];
			rg(PGD_IDX_FILL_VAL, {4'h0, fv});
			rg(PGD_IDX_FILL_EN, {4'h0, fe});
			rg(PGD_IDX_CMP_COLOR, {4'h0, cc});
			rg(PGD_IDX_ROTATE, {3'h0, fn, rot});
			rg(PGD_IDX_READ_PLANE, {6'h0, rp});
			rg(PGD_IDX_MODE, {1'b0, x[4:3], 1'b0, rm, 1'b0, wm});
			rg(PGD_IDX_MISC, {4'h0, x[6:5], 1'b0, x[7]});
			rg(PGD_IDX_CMP_EN, {4'h0, ce});
			rg(PGD_IDX_BIT_MASK, mk);
			rq(PGD_IDX_ROTATE, {3'h0, fn, rot});
			rq(PGD_IDX_MODE, {1'b0, x[4:3], 1'b0, rm, 1'b0, wm});
			rq(PGD_IDX_BIT_MASK, mk);
			cmp("load256", {7'h0, x[4]}, {7'h0, l256});
			cmp("shift", {7'h0, x[3] & ~x[4]}, {7'h0, sfm});
			cmp("map", {6'h0, x[6:5]}, {6'h0, map});
			cmp("gfx", {7'h0, x[7]}, {7'h0, gfx});
			mem(0, a); // latch load
			mem(1, a); // write modes
			mem(0, a); // read back
		end
		$display("test datapath_loop done");
		// chained writes hit one plane pair; odd/even reads pick by a0
		ch = 1;
		oe = 1;
		{wm, fn, rot, mk, fe, rm} = {PGD_WM0, 2'h0, 3'h0, 8'hff, 4'h0, 1'b0};
		rg(PGD_IDX_FILL_EN, 8'h00);
		rg(PGD_IDX_ROTATE, 8'h00);
		rg(PGD_IDX_BIT_MASK, 8'hff);
		rg(PGD_IDX_MODE, 8'h10);
		rg(PGD_IDX_MISC, 8'h02);
		for (int i = 0; i < 8; i++) begin
			rp = 2'(i);
			a = 4'($random(seed));
			rg(PGD_IDX_READ_PLANE, {6'h0, rp});
			mem(1, a);
			mem(0, a);
			mem(0, a ^ 4'h1);
		end
		$display("test chain_oddeven done");
		test_done;
	end
endmodule

/* verilog/pgd_datapath.sv */
// Contract
// - read mode bit clear returns selected plane; set returns colour compare
// - write mode 0 combines rotated cpu byte with each latch, writes all planes, or with chaining only the plane pair a0 selects
// - write mode 0 enabled fill planes get fill bit in all eight bits
// - write mode 0 masked-off bits take the latch value alone
// - write mode 1 writes latches unmodified, ignoring mask, function, fill
// - write mode 2 replicates cpu bit n across byte for plane n
// - write mode 2 uses mask and function; fill overrides; no rotation
// - write mode 3 source is fill bit; rotated byte and mask form mask
// - odd/even read picks even plane when a0 is 0, odd plane otherwise
// - mode bit 6 clear lets bit 5 steer loading; set selects 256 colour
// - mode bit 5 selects four-colour compatibility pixel formatting
// - misc bits 3:2 select the memory map window
// - misc bit 1 replaces cpu a0 with high address bit, chaining planes
// - misc bit 0 selects graphics, clear selects text
// - compare enable bit per plane includes it in the colour comparison
// - bit mask 1 passes cpu bit, 0 writes the latch bit
// - in write modes 0 and 3 cpu write data is rotated before the mask applies
// - function select: move, and, or, xor; modes 0, 2, 3 only
// - rotate count right-rotates the cpu byte by 0 to 7
// - fill enable per plane; no effect in write modes 1 and 3
// - read mode 1 returns 1 where pixel colour matches the compare colour
`timescale 1ns/1ps
module pgd_datapath
	import pgd_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// i/o register port
	input wire logic IO_WR_I,
	input wire logic IO_RD_I,
	input wire logic [15:0] IO_ADDR_I,
	input wire logic [7:0] IO_WDATA_I,
	output logic [7:0] IO_RDATA_O,
	output logic IO_RVALID_O,
	// cpu memory access
	input wire logic MEM_WR_I,
	input wire logic MEM_RD_I,
	input wire logic [ADDR_W-1:0] MEM_ADDR_I,
	input wire logic [7:0] MEM_WDATA_I,
	output logic [7:0] MEM_RDATA_O,
	output logic MEM_RVALID_O,
	// plane memory side
	input wire logic [31:0] PLANE_RDATA_I,
	input wire logic PLANE_RVALID_I,
	output logic PLANE_RD_O,
	output logic PLANE_WR_O,
	output logic [ADDR_W-1:0] PLANE_ADDR_O,
	output logic [31:0] PLANE_WDATA_O,
	output logic [3:0] PLANE_SEL_O,
	// mode outputs toward the display side
	output logic GFX_MODE_O,
	output logic [1:0] MEM_MAP_O,
	output logic SHIFT_FMT_O,
	output logic LOAD_256_O
);
	typedef enum logic [1:0] {PGD_IDLE, PGD_READ} pgd_state_t;

	typedef struct packed {
		pgd_state_t st;
		logic [3:0] index;
		logic [3:0] fill_val;
		logic [3:0] fill_en;
		logic [3:0] cmp_color;
		logic [4:0] rotate;
		logic [1:0] read_plane;
		logic [6:0] mode;
		logic [3:0] misc;
		logic [3:0] cmp_en;
		logic [7:0] bit_mask;
		logic [7:0] latch0;
		logic [7:0] latch1;
		logic [7:0] latch2;
		logic [7:0] latch3;
		logic rd_a0;
		logic [7:0] io_rdata;
		logic io_rvalid;
		logic [7:0] mem_rdata;
		logic mem_rvalid;
		logic pl_rd;
		logic pl_wr;
		logic [ADDR_W-1:0] pl_addr;
		logic [31:0] pl_wdata;
		logic [3:0] pl_sel;
	} pgd_regs_t;

	pgd_regs_t r_q;
	pgd_regs_t r_d;

	// circular right rotate, bit 0 wraps into bit 7
	function automatic logic [7:0] rot_right(input logic [7:0] v,
		input logic [2:0] n);
		logic [15:0] w;
		w = {v, v} >> n;
		return w[7:0];
	endfunction

	// the four logic functions between source and latch
	function automatic logic [7:0] alu(input logic [1:0] fn,
		input logic [7:0] s, input logic [7:0] l);
		logic [7:0] o;
		unique case (fn)
			PGD_FN_MOVE: o = s;
			PGD_FN_AND: o = s & l;
			PGD_FN_OR: o = s | l;
			PGD_FN_XOR: o = s ^ l;
		endcase
		return o;
	endfunction

	// register readback by index; unmapped indices read zero
	function automatic logic [7:0] reg_read(input pgd_regs_t r);
		logic [7:0] o;
		o = 8'h00;
		unique case (r.index)
			PGD_IDX_FILL_VAL: o = {4'h0, r.fill_val};
			PGD_IDX_FILL_EN: o = {4'h0, r.fill_en};
			PGD_IDX_CMP_COLOR: o = {4'h0, r.cmp_color};
			PGD_IDX_ROTATE: o = {3'h0, r.rotate};
			PGD_IDX_READ_PLANE: o = {6'h00, r.read_plane};
			PGD_IDX_MODE: o = {1'b0, r.mode};
			PGD_IDX_MISC: o = {4'h0, r.misc};
			PGD_IDX_CMP_EN: o = {4'h0, r.cmp_en};
			PGD_IDX_BIT_MASK: o = r.bit_mask;
			default: o = 8'h00;
		endcase
		return o;
	endfunction

	logic [7:0] rd_lat [4];
	logic [7:0] cpu_rot;
	logic [7:0] eff_mask;
	logic [7:0] src;
	logic [7:0] res;
	logic [7:0] cmp_res;
	logic [1:0] wmode;
	logic [1:0] rsel;
	logic [1:0] fn;

	always_comb begin
		r_d = r_q;
		wmode = r_q.mode[1:0];
		fn = r_q.rotate[PGD_ROT_FUNC_LSB +: 2];
		cpu_rot = rot_right(MEM_WDATA_I, r_q.rotate[2:0]);
		eff_mask = r_q.bit_mask;
		src = 8'h00;
		res = 8'h00;
		cmp_res = 8'hff;
		rsel = r_q.read_plane;
		rd_lat[0] = PLANE_RDATA_I[7:0];
		rd_lat[1] = PLANE_RDATA_I[15:8];
		rd_lat[2] = PLANE_RDATA_I[23:16];
		rd_lat[3] = PLANE_RDATA_I[31:24];
		r_d.io_rvalid = 1'b0;
		r_d.mem_rvalid = 1'b0;
		r_d.pl_rd = 1'b0;
		r_d.pl_wr = 1'b0;

		// register port: index at one address, data at the other
		if (IO_WR_I && IO_ADDR_I == PGD_PORT_INDEX) begin
			r_d.index = IO_WDATA_I[3:0];
		end else if (IO_WR_I && IO_ADDR_I == PGD_PORT_DATA) begin
			unique case (r_q.index)
				PGD_IDX_FILL_VAL: r_d.fill_val = IO_WDATA_I[3:0];
				PGD_IDX_FILL_EN: r_d.fill_en = IO_WDATA_I[3:0];
				PGD_IDX_CMP_COLOR: r_d.cmp_color = IO_WDATA_I[3:0];
				PGD_IDX_ROTATE: r_d.rotate = IO_WDATA_I[4:0];
				PGD_IDX_READ_PLANE: r_d.read_plane = IO_WDATA_I[1:0];
				PGD_IDX_MODE: r_d.mode = {IO_WDATA_I[6:3], 1'b0,
					IO_WDATA_I[1:0]};
				PGD_IDX_MISC: r_d.misc = IO_WDATA_I[3:0];
				PGD_IDX_CMP_EN: r_d.cmp_en = IO_WDATA_I[3:0];
				PGD_IDX_BIT_MASK: r_d.bit_mask = IO_WDATA_I;
				default: ;
			endcase
		end
		if (IO_RD_I) begin
			r_d.io_rvalid = 1'b1;
			r_d.io_rdata = 8'h00;
			if (IO_ADDR_I == PGD_PORT_INDEX) begin
				r_d.io_rdata = {4'h0, r_q.index};
			end else if (IO_ADDR_I == PGD_PORT_DATA) begin
				r_d.io_rdata = reg_read(r_q);
			end
		end

		// colour compare over the freshly read planes
		for (int b = 0; b < 8; b++) begin
			for (int p = 0; p < 4; p++) begin
				if (r_q.cmp_en[p] &&
					rd_lat[p][b] != r_q.cmp_color[p]) begin
					cmp_res[b] = 1'b0;
				end
			end
		end
		// odd/even read picks within the pair by a0
		if (r_q.mode[PGD_MODE_ODDEVEN_BIT]) begin
			rsel = {r_q.read_plane[1], r_q.rd_a0};
		end

		// plane memory write, per-plane source and mask
		if (MEM_WR_I && r_q.st == PGD_IDLE) begin
			r_d.pl_wr = 1'b1;
			r_d.pl_sel = 4'hf;
			r_d.pl_addr = MEM_ADDR_I;
			if (r_q.misc[PGD_MISC_CHAIN_BIT]) begin
				// a0 steers the plane pair, the high bit takes its place
				r_d.pl_addr = {MEM_ADDR_I[ADDR_W-1:1],
					MEM_ADDR_I[ADDR_W-1]};
				r_d.pl_sel = MEM_ADDR_I[0] ? 4'ha : 4'h5;
			end
			if (wmode == PGD_WM3) begin
				eff_mask = cpu_rot & r_q.bit_mask;
			end
			for (int p = 0; p < 4; p++) begin
				unique case (wmode)
					PGD_WM0: src = cpu_rot;
					PGD_WM2: src = {8{MEM_WDATA_I[p]}};
					default: src = {8{r_q.fill_val[p]}};
				endcase
				if (wmode != PGD_WM3 && r_q.fill_en[p]) begin
					src = {8{r_q.fill_val[p]}};
				end
				res = alu(fn, src, r_q_latch(p));
				res = (res & eff_mask) |
					(r_q_latch(p) & ~eff_mask);
				if (wmode == PGD_WM1) begin
					res = r_q_latch(p);
				end
				r_d.pl_wdata[p*8 +: 8] = res;
			end
		end else if (MEM_RD_I && r_q.st == PGD_IDLE) begin
			// one read in flight; reads and writes arriving before its data are dropped
			r_d.st = PGD_READ;
			r_d.pl_rd = 1'b1;
			r_d.pl_sel = 4'hf;
			r_d.pl_addr = MEM_ADDR_I;
			r_d.rd_a0 = MEM_ADDR_I[0];
			// chained reads address the same pair row as chained writes
			if (r_q.misc[PGD_MISC_CHAIN_BIT]) begin
				r_d.pl_addr[0] = MEM_ADDR_I[ADDR_W-1];
			end
		end

		if (r_q.st == PGD_READ && PLANE_RVALID_I) begin
			r_d.st = PGD_IDLE;
			r_d.latch0 = rd_lat[0];
			r_d.latch1 = rd_lat[1];
			r_d.latch2 = rd_lat[2];
			r_d.latch3 = rd_lat[3];
			r_d.mem_rvalid = 1'b1;
			r_d.mem_rdata = r_q.mode[PGD_MODE_READ_BIT] ? cmp_res
				: rd_lat[rsel];
		end

		if (RST_I) begin
			r_d = '0;
			r_d.st = PGD_IDLE;
			r_d.bit_mask = PGD_RST_BIT_MASK;
			r_d.cmp_en = PGD_RST_CMP_EN[3:0];
		end
	end

	// latch lookup by plane number
	function automatic logic [7:0] r_q_latch(input int p);
		logic [7:0] o;
		unique case (p[1:0])
			2'd0: o = r_q.latch0;
			2'd1: o = r_q.latch1;
			2'd2: o = r_q.latch2;
			default: o = r_q.latch3;
		endcase
		return o;
	endfunction

	always_ff @(posedge SYS_CLK_I) begin
		r_q <= r_d;
	end

	assign IO_RDATA_O = r_q.io_rdata;
	assign IO_RVALID_O = r_q.io_rvalid;
	assign MEM_RDATA_O = r_q.mem_rdata;
	assign MEM_RVALID_O = r_q.mem_rvalid;
	assign PLANE_RD_O = r_q.pl_rd;
	assign PLANE_WR_O = r_q.pl_wr;
	assign PLANE_ADDR_O = r_q.pl_addr;
	assign PLANE_WDATA_O = r_q.pl_wdata;
	assign PLANE_SEL_O = r_q.pl_sel;
	// mode bits handed to the display side
	assign GFX_MODE_O = r_q.misc[PGD_MISC_GFX_BIT];
	assign MEM_MAP_O = r_q.misc[3:2];
	// 256-colour loading overrides the shift format bit
	assign LOAD_256_O = r_q.mode[PGD_MODE_256_BIT];
	assign SHIFT_FMT_O = r_q.mode[PGD_MODE_SHIFT_BIT] &
		~r_q.mode[PGD_MODE_256_BIT];
endmodule

/* verilog/pgd_pkg.sv */
package pgd_pkg;
	// i/o port addresses and register indices
	localparam logic [15:0] PGD_PORT_INDEX = 16'h03ce;
	localparam logic [15:0] PGD_PORT_DATA = 16'h03cf;
	localparam logic [3:0] PGD_IDX_FILL_VAL = 4'h0;
	localparam logic [3:0] PGD_IDX_FILL_EN = 4'h1;
	localparam logic [3:0] PGD_IDX_CMP_COLOR = 4'h2;
	localparam logic [3:0] PGD_IDX_ROTATE = 4'h3;
	localparam logic [3:0] PGD_IDX_READ_PLANE = 4'h4;
	localparam logic [3:0] PGD_IDX_MODE = 4'h5;
	localparam logic [3:0] PGD_IDX_MISC = 4'h6;
	localparam logic [3:0] PGD_IDX_CMP_EN = 4'h7;
	localparam logic [3:0] PGD_IDX_BIT_MASK = 4'h8;
	// field positions
	localparam int PGD_MODE_READ_BIT = 3;
	localparam int PGD_MODE_ODDEVEN_BIT = 4;
	localparam int PGD_MODE_SHIFT_BIT = 5;
	localparam int PGD_MODE_256_BIT = 6;
	localparam int PGD_MISC_GFX_BIT = 0;
	localparam int PGD_MISC_CHAIN_BIT = 1;
	localparam int PGD_ROT_FUNC_LSB = 3;
	// reset values
	localparam logic [7:0] PGD_RST_ZERO = 8'h00;
	localparam logic [7:0] PGD_RST_BIT_MASK = 8'hff;
	localparam logic [7:0] PGD_RST_CMP_EN = 8'h0f;
	// write modes and logic functions
	localparam logic [1:0] PGD_WM0 = 2'h0;
	localparam logic [1:0] PGD_WM1 = 2'h1;
	localparam logic [1:0] PGD_WM2 = 2'h2;
	localparam logic [1:0] PGD_WM3 = 2'h3;
	localparam logic [1:0] PGD_FN_MOVE = 2'h0;
	localparam logic [1:0] PGD_FN_AND = 2'h1;
	localparam logic [1:0] PGD_FN_OR = 2'h2;
	localparam logic [1:0] PGD_FN_XOR = 2'h3;
endpackage
